//--- design/adct_top.sv
// Register slave and two dedicated core sequencers with common interrupt
//
// Added by the designer: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// Behaviour
// - Per-core ready interrupt enable gates that core's ready event to interrupt
// - Conversion delay equals delay field plus two core clock periods
// - Core keeps sampling through the whole conversion delay
// - Conversion delay applies only when the core's delay enable is set
// - Delay disabled: sampling stops at trigger, conversion on next core clock
// - Early flag and interrupt come lead-code-plus-one core clocks before data
// - Upper delay register bits read zero and ignore writes
// - Common warm-up field sets power-up delay before a core is ready
module adct_top
  import adct_pkg::*;
#(
  parameter int unsigned WARM_SHIFT = 0
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [DATA_W-1:0] avs_writedata_i,
  output logic [DATA_W-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [NUM_CORES-1:0] trigger_i,
  output logic [NUM_CORES-1:0] sample_o,
  output logic [NUM_CORES-1:0] convert_o,
  output logic [NUM_CORES-1:0] data_ready_o,
  output logic irq_o
);

  // Bus slave state
  logic wait_r, wait_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic wr_en;

  // Software registers
  adct_cfg_s cfg_r [NUM_CORES];
  adct_cfg_s cfg_nxt [NUM_CORES];
  logic [3:0] powerup_delay_r, powerup_delay_nxt;
  logic shared_ready_irq_enable_r, shared_ready_irq_enable_nxt;
  logic [NUM_CORES-1:0] ready_irq_en_r, ready_irq_en_nxt;
  logic [NUM_CORES-1:0] power_r, power_nxt;
  logic [NUM_CORES-1:0] early_flag_r, early_flag_nxt;

  // Event state
  logic [NUM_CORES-1:0] ready_prev_r, ready_prev_nxt;
  logic irq_r, irq_nxt;
  logic [NUM_CORES-1:0] irq_src;
  logic [NUM_CORES-1:0] data_ready_r, data_ready_nxt;

  adct_stat_s stat [NUM_CORES];
  logic [NUM_CORES-1:0] core_ready, core_early, core_done, core_sample;
  logic [NUM_CORES-1:0] core_convert;

  genvar g;
  generate
    for (g = 0; g < NUM_CORES; g++) begin : g_core
      adct_core #(
        .WARM_SHIFT(WARM_SHIFT)
      ) u_core (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .cfg_i(cfg_r[g]),
        .power_i(power_r[g]),
        .warm_code_i(powerup_delay_r),
        .trigger_i(trigger_i[g]),
        .stat_o(stat[g])
      );
      assign core_ready[g] = stat[g].ready;
      assign core_early[g] = stat[g].early;
      assign core_done[g] = stat[g].done;
      assign core_sample[g] = stat[g].sample;
      assign core_convert[g] = stat[g].convert;
    end
  endgenerate

  assign sample_o = core_sample;
  assign convert_o = core_convert;
  assign data_ready_o = data_ready_r;
  assign avs_waitrequest_o = wait_r;
  assign avs_readdata_o = rdata_r;
  assign irq_o = irq_r;

  // Bus handshake: one wait cycle, then the access completes
  always_comb begin
    wait_nxt = 1'b1;
    if ((avs_read_i || avs_write_i) && wait_r) begin
      wait_nxt = 1'b0;
    end
    wr_en = avs_write_i && !wait_r;
  end

  function automatic logic [DATA_W-1:0] cfg_word(input adct_cfg_s c);
    logic [DATA_W-1:0] w;
    w = RD_ZERO;
    w[CFG_LEAD_MSB:CFG_LEAD_LSB] = c.lead;
    w[CFG_RES_MSB:CFG_RES_LSB] = c.res;
    w[CFG_DIV_MSB:CFG_DIV_LSB] = c.div;
    return w;
  endfunction

  function automatic logic [DATA_W-1:0] dly_word(input adct_cfg_s c);
    logic [DATA_W-1:0] w;
    w = RD_ZERO;
    w[DLY_CNT_MSB:DLY_CNT_LSB] = c.conv_cnt;
    return w;
  endfunction

  // Read data prepared during the wait cycle
  always_comb begin
    rdata_nxt = RD_ZERO;
    unique case (avs_address_i)
      REG_DLY0: rdata_nxt = dly_word(cfg_r[0]);
      REG_DLY1: rdata_nxt = dly_word(cfg_r[1]);
      REG_CFG0: rdata_nxt = cfg_word(cfg_r[0]);
      REG_CFG1: rdata_nxt = cfg_word(cfg_r[1]);
      REG_DLYEN: begin
        rdata_nxt[CORE_LO_LSB] = cfg_r[0].dly_en;
        rdata_nxt[CORE_LO_MSB] = cfg_r[1].dly_en;
      end
      REG_RDYIRQ: begin
        rdata_nxt[WARM_MSB:WARM_LSB] = powerup_delay_r;
        rdata_nxt[SHR_IE_BIT] = shared_ready_irq_enable_r;
        rdata_nxt[CORE_LO_MSB:CORE_LO_LSB] = ready_irq_en_r;
      end
      REG_PWR: begin
        rdata_nxt[CORE_HI_MSB:CORE_HI_LSB] = core_ready;
        rdata_nxt[CORE_LO_MSB:CORE_LO_LSB] = power_r;
      end
      REG_STAT: begin
        rdata_nxt[CORE_HI_MSB:CORE_HI_LSB] = core_convert;
        rdata_nxt[CORE_LO_MSB:CORE_LO_LSB] = early_flag_r;
      end
    endcase
    if (!(avs_read_i && wait_r)) begin
      rdata_nxt = rdata_r;
    end
  end

  // Register writes land at the edge where waitrequest is low
  always_comb begin
    cfg_nxt = cfg_r;
    powerup_delay_nxt = powerup_delay_r;
    shared_ready_irq_enable_nxt = shared_ready_irq_enable_r;
    ready_irq_en_nxt = ready_irq_en_r;
    power_nxt = power_r;
    early_flag_nxt = early_flag_r;
    if (wr_en) begin
      unique case (avs_address_i)
        REG_DLY0: cfg_nxt[0].conv_cnt =
          avs_writedata_i[DLY_CNT_MSB:DLY_CNT_LSB];
        REG_DLY1: cfg_nxt[1].conv_cnt =
          avs_writedata_i[DLY_CNT_MSB:DLY_CNT_LSB];
        REG_CFG0, REG_CFG1: begin
          cfg_nxt[avs_address_i[0]].lead =
            avs_writedata_i[CFG_LEAD_MSB:CFG_LEAD_LSB];
          cfg_nxt[avs_address_i[0]].res =
            avs_writedata_i[CFG_RES_MSB:CFG_RES_LSB];
          cfg_nxt[avs_address_i[0]].div =
            avs_writedata_i[CFG_DIV_MSB:CFG_DIV_LSB];
        end
        REG_DLYEN: begin
          cfg_nxt[0].dly_en = avs_writedata_i[CORE_LO_LSB];
          cfg_nxt[1].dly_en = avs_writedata_i[CORE_LO_MSB];
        end
        REG_RDYIRQ: begin
          powerup_delay_nxt = avs_writedata_i[WARM_MSB:WARM_LSB];
          shared_ready_irq_enable_nxt = avs_writedata_i[SHR_IE_BIT];
          ready_irq_en_nxt = avs_writedata_i[CORE_LO_MSB:CORE_LO_LSB];
        end
        REG_PWR: power_nxt = avs_writedata_i[CORE_LO_MSB:CORE_LO_LSB];
        REG_STAT: early_flag_nxt = early_flag_r
          & ~avs_writedata_i[CORE_LO_MSB:CORE_LO_LSB];
        default: ;
      endcase
    end
    // A new early event wins over a same-cycle clear
    early_flag_nxt = early_flag_nxt | core_early;
  end

  // Common interrupt: gated ready events and early events
  always_comb begin
    ready_prev_nxt = core_ready;
    // Data ready takes the same one-cycle lag as the early interrupt, so the
    // lead between them stays a whole number of core clocks
    data_ready_nxt = core_done;
    irq_src = (core_ready & ~ready_prev_r & ready_irq_en_r)
      | core_early;
    irq_nxt = |irq_src;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_r <= 1'b1;
      rdata_r <= RD_ZERO;
    end else begin
      wait_r <= wait_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_r <= '{default: '0};
      powerup_delay_r <= REG_RESET[WARM_MSB:WARM_LSB];
      shared_ready_irq_enable_r <= REG_RESET[SHR_IE_BIT];
      ready_irq_en_r <= REG_RESET[CORE_LO_MSB:CORE_LO_LSB];
      power_r <= REG_RESET[CORE_LO_MSB:CORE_LO_LSB];
      early_flag_r <= REG_RESET[CORE_LO_MSB:CORE_LO_LSB];
    end else begin
      cfg_r <= cfg_nxt;
      powerup_delay_r <= powerup_delay_nxt;
      shared_ready_irq_enable_r <= shared_ready_irq_enable_nxt;
      ready_irq_en_r <= ready_irq_en_nxt;
      power_r <= power_nxt;
      early_flag_r <= early_flag_nxt;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ready_prev_r <= '0;
      irq_r <= 1'b0;
      data_ready_r <= '0;
    end else begin
      ready_prev_r <= ready_prev_nxt;
      irq_r <= irq_nxt;
      data_ready_r <= data_ready_nxt;
    end
  end

  chk_ready_irq_raise: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    $rose(core_ready[0]) && ready_irq_en_r[0] |=> irq_o)
    else $error("enabled ready event raised no interrupt");

  chk_ready_irq_masked: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    irq_o |-> $past(core_early != 2'b00
      || (core_ready & ~ready_prev_r & ready_irq_en_r) != 2'b00))
    else $error("interrupt without enabled cause");

  chk_early_irq: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    core_early[1] |=> irq_o && early_flag_r[1])
    else $error("early event lost");

  chk_unused_zero: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    !wait_r && avs_read_i && avs_address_i == REG_DLY0
    |-> avs_readdata_o[DATA_W-1:DLY_CNT_MSB+1] == '0)
    else $error("unused delay bits read nonzero");

  chk_bus_answer: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (avs_read_i || avs_write_i) && wait_r |=> !wait_r ##1 wait_r)
    else $error("bus answer not in one wait cycle");

  chk_ready_irq_core1: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    $rose(core_ready[1]) && ready_irq_en_r[1] |=> irq_o)
    else $error("core 1 ready event raised no interrupt");

  chk_early_flag_set: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    core_early[0] |=> early_flag_r[0])
    else $error("early flag not set");

  chk_early_flag_clear: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    wr_en && avs_address_i == REG_STAT && avs_writedata_i[0]
      && !core_early[0] |=> !early_flag_r[0])
    else $error("early flag not cleared");

  chk_ready_pulse: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    data_ready_o[0] |=> !data_ready_o[0])
    else $error("data ready longer than one cycle");

  chk_delay_write: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    wr_en && avs_address_i == REG_DLY0
    |=> cfg_r[0].conv_cnt
      == $past(avs_writedata_i[DLY_CNT_MSB:DLY_CNT_LSB]))
    else $error("delay field write lost");

  chk_warm_write: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    wr_en && avs_address_i == REG_RDYIRQ
    |=> powerup_delay_r == $past(avs_writedata_i[WARM_MSB:WARM_LSB]))
    else $error("warm-up field write lost");

  chk_wait_idle: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    !(avs_read_i || avs_write_i) |=> avs_waitrequest_o)
    else $error("waitrequest low without request");

  chk_power_abort: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    !power_r[0] |=> !core_ready[0])
    else $error("unpowered core reports ready");

  chk_power_read: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    avs_read_i && wait_r && avs_address_i == REG_PWR
    |=> avs_readdata_o[CORE_LO_MSB:CORE_LO_LSB] == $past(power_r))
    else $error("power bits read wrong");

endmodule // adct_top

//--- inc/adct_pkg.sv
// Shared constants, types and helpers for the converter core timing block
package adct_pkg;

  localparam int ADDR_W = 3;
  localparam int DATA_W = 32;
  localparam int NUM_CORES = 2;

  // Register word indices
  localparam logic [ADDR_W-1:0] REG_DLY0 = 3'h0;
  localparam logic [ADDR_W-1:0] REG_DLY1 = 3'h1;
  localparam logic [ADDR_W-1:0] REG_CFG0 = 3'h2;
  localparam logic [ADDR_W-1:0] REG_CFG1 = 3'h3;
  localparam logic [ADDR_W-1:0] REG_DLYEN = 3'h4;
  localparam logic [ADDR_W-1:0] REG_RDYIRQ = 3'h5;
  localparam logic [ADDR_W-1:0] REG_PWR = 3'h6;
  localparam logic [ADDR_W-1:0] REG_STAT = 3'h7;

  // Field positions
  localparam int DLY_CNT_MSB = 9;
  localparam int DLY_CNT_LSB = 0;
  localparam int CFG_LEAD_MSB = 12;
  localparam int CFG_LEAD_LSB = 10;
  localparam int CFG_RES_MSB = 9;
  localparam int CFG_RES_LSB = 8;
  localparam int CFG_DIV_MSB = 6;
  localparam int CFG_DIV_LSB = 0;
  localparam int WARM_MSB = 11;
  localparam int WARM_LSB = 8;
  localparam int SHR_IE_BIT = 7;
  localparam int CORE_LO_MSB = 1;
  localparam int CORE_LO_LSB = 0;
  localparam int CORE_HI_MSB = 9;
  localparam int CORE_HI_LSB = 8;

  localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;
  localparam logic [15:0] REG_RESET = 16'h0000;

  // Timing figures, in core clock periods unless noted
  localparam logic [15:0] DLY_OFFSET = 16'h0002;
  localparam logic [15:0] LEAD_OFFSET = 16'h0001;
  localparam logic [15:0] CONV_MIN_LEN = 16'h0009;
  localparam logic [7:0] DIV_MIN = 8'h02;
  localparam logic [3:0] WARM_MIN_EXP = 4'h4;
  localparam logic [15:0] CNT_ONE = 16'h0001;

  typedef struct packed {
    logic dly_en;
    logic [9:0] conv_cnt;
    logic [2:0] lead;
    logic [1:0] res;
    logic [6:0] div;
  } adct_cfg_s;

  typedef struct packed {
    logic ready;
    logic sample;
    logic convert;
    logic early;
    logic done;
  } adct_stat_s;

  typedef enum logic [2:0] {
    ST_OFF, ST_WARM, ST_IDLE, ST_DELAY, ST_START, ST_CONV
  } adct_core_e;

  // Source clock cycles per core clock period
  function automatic logic [7:0] div_cycles(input logic [6:0] code);
    return (code == 7'h00) ? DIV_MIN : {code, 1'b0};
  endfunction

  // Power-up delay in source clock cycles, scaled down by shift
  function automatic logic [15:0] warm_cycles(input logic [3:0] code,
                                              input int unsigned shift);
    logic [3:0] e;
    logic [15:0] v;
    e = (code < WARM_MIN_EXP) ? WARM_MIN_EXP : code;
    v = CNT_ONE << e;
    v = v >> shift;
    if (v == 16'h0000) begin
      v = CNT_ONE;
    end
    return v;
  endfunction

  // Conversion length in core clocks: result bits plus three
  function automatic logic [15:0] conv_len(input logic [1:0] res);
    return CONV_MIN_LEN + {13'h0000, res, 1'b0};
  endfunction

endpackage

//--- design/adct_core.sv
// One dedicated converter core sequencer: warm-up, sampling, conversion
`timescale 1ns/1ps
module adct_core
  import adct_pkg::*;
#(
  parameter int unsigned WARM_SHIFT = 0
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire adct_cfg_s cfg_i,
  input wire logic power_i,
  input wire logic [3:0] warm_code_i,
  input wire logic trigger_i,
  output adct_stat_s stat_o
);

  adct_core_e state_r, state_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [7:0] div_r, div_nxt;
  adct_stat_s stat_r, stat_nxt;
  logic tick;

  assign stat_o = stat_r;

  always_comb begin
    // A divider lowered below the running count ends the period at once
    tick = (div_r >= div_cycles(cfg_i.div) - 8'h01);
    div_nxt = tick ? 8'h00 : div_r + 8'h01;
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    stat_nxt = '0;
    unique case (state_r)
      ST_OFF: begin
        if (power_i) begin
          state_nxt = ST_WARM;
          cnt_nxt = warm_cycles(warm_code_i, WARM_SHIFT);
        end
      end
      ST_WARM: begin
        if (cnt_r == CNT_ONE) begin
          state_nxt = ST_IDLE;
        end else begin
          cnt_nxt = cnt_r - CNT_ONE;
        end
      end
      ST_IDLE: begin
        if (trigger_i && cfg_i.dly_en) begin
          state_nxt = ST_DELAY;
          cnt_nxt = {6'h00, cfg_i.conv_cnt} + DLY_OFFSET;
        end else if (trigger_i) begin
          state_nxt = ST_START;
        end
      end
      ST_DELAY: begin
        if (tick && cnt_r == CNT_ONE) begin
          state_nxt = ST_CONV;
          cnt_nxt = conv_len(cfg_i.res);
        end else if (tick) begin
          cnt_nxt = cnt_r - CNT_ONE;
        end
      end
      ST_START: begin
        if (tick) begin
          state_nxt = ST_CONV;
          cnt_nxt = conv_len(cfg_i.res);
        end
      end
      ST_CONV: begin
        if (tick) begin
          cnt_nxt = cnt_r - CNT_ONE;
          stat_nxt.early = (cnt_nxt == {13'h0000, cfg_i.lead} + LEAD_OFFSET);
          if (cnt_r == CNT_ONE) begin
            stat_nxt.done = 1'b1;
            state_nxt = ST_IDLE;
          end
        end
      end
    endcase
    if (!power_i) begin
      state_nxt = ST_OFF;
      stat_nxt.early = 1'b0;
      stat_nxt.done = 1'b0;
    end
    stat_nxt.ready = (state_nxt != ST_OFF) && (state_nxt != ST_WARM);
    // Sampling continues through the delay and stops at conversion
    stat_nxt.sample = (state_nxt == ST_IDLE) || (state_nxt == ST_DELAY);
    stat_nxt.convert = (state_nxt == ST_CONV);
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= ST_OFF;
      cnt_r <= 16'h0000;
      div_r <= 8'h00;
      stat_r <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      div_r <= div_nxt;
      stat_r <= stat_nxt;
    end
  end

  sequence s_trig_delayed;
    state_r == ST_IDLE && power_i && trigger_i && cfg_i.dly_en;
  endsequence

  chk_delay_enable_path: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    s_trig_delayed |=> state_r == ST_DELAY)
    else $error("delay enable did not enter delay");

  chk_delay_count_load: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    s_trig_delayed |=> cnt_r == {6'h00, $past(cfg_i.conv_cnt)} + DLY_OFFSET)
    else $error("delay count not value plus two");

  chk_bypass_stop: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    state_r == ST_IDLE && power_i && trigger_i && !cfg_i.dly_en
    |=> state_r == ST_START && !stat_r.sample)
    else $error("sampling did not stop at trigger");

  chk_sample_hold: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    state_r == ST_DELAY && power_i |-> stat_r.sample && !stat_r.convert)
    else $error("sampling dropped during delay");

  chk_early_lead: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    stat_r.early |-> state_r == ST_CONV
      && cnt_r == {13'h0000, cfg_i.lead} + LEAD_OFFSET)
    else $error("early flag at wrong lead");

  chk_conv_length: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    state_r != ST_CONV ##1 state_r == ST_CONV |-> cnt_r == conv_len(cfg_i.res))
    else $error("conversion length mismatch");

  chk_warm_load: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    state_r == ST_OFF && power_i
    |=> state_r == ST_WARM && !stat_r.ready
      && cnt_r == warm_cycles($past(warm_code_i), WARM_SHIFT))
    else $error("warm-up count not loaded");

endmodule // adct_core

//--- testbench/adct_trig_src.sv
// Trigger source model that feeds the core trigger inputs
`timescale 1ns/1ps
module adct_trig_src (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [1:0] fire_i,
  output logic [1:0] trigger_o
);
  // One registered trigger pulse per cycle of fire request
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      trigger_o <= 2'h0;
    end else begin
      trigger_o <= fire_i;
    end
  end
endmodule // adct_trig_src

//--- testbench/adct_core_timing_control_bench.sv
// Self-checking bench for the converter core timing block
`timescale 1ns/1ps
module adct_core_timing_control_bench;
  import adct_pkg::*;
  localparam int WS = 8;
  typedef struct {
    logic [31:0] exp;
    bit chk;
  } adct_rd_s;
  typedef struct {
    int slo;
    int shi;
    int conv;
    int lead;
  } adct_cv_s;
  logic sys_clk_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic [ADDR_W-1:0] adr = 3'h0;
  logic rd = 1'h0;
  logic wr = 1'h0;
  logic [DATA_W-1:0] wdat = 32'h0000_0000;
  logic [DATA_W-1:0] rdat;
  logic wreq;
  logic [1:0] fire = 2'h0;
  logic [1:0] trig;
  logic [1:0] smp;
  logic [1:0] cnv;
  logic [1:0] drdy;
  logic irq;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int irq_n = 0;
  int t_irq = 0;
  int t_trig[2];
  int slen[2];
  int ccnt[2];
  logic [1:0] busy = 2'h0;
  logic [1:0] ps = 2'h0;
  logic [31:0] seed = 32'h0000_caa7;
  logic [31:0] last = 32'h0000_0000;
  adct_rd_s rd_q[$];
  adct_cv_s cv_q[2][$];
  logic [2:0] ra[4] = '{REG_DLY0, REG_CFG1, REG_RDYIRQ, REG_DLYEN};
  logic [31:0] rm[4] = '{32'h0000_03ff, 32'h0000_1f7f, 32'h0000_0f83,
                         32'h0000_0003};

  initial begin
    forever #20 sys_clk_i = ~sys_clk_i;
  end

  adct_top #(.WARM_SHIFT(WS)) u_dut (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .trigger_i(trig),
    .sample_o(smp), .convert_o(cnv), .data_ready_o(drdy), .irq_o(irq)
  );

  adct_trig_src u_trig (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .fire_i(fire),
    .trigger_o(trig)
  );

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: read %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int got, input int lo, input int hi);
    cmp_count++;
    if (got < lo || got > hi) begin
      bad_count++;
      $display("mismatch at %0t: count %0d not in %0d..%0d", $time, got,
               lo, hi);
    end
  endtask

  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // One bus access; reads note their expected word for the monitor
  task automatic acc(input bit w, input logic [2:0] a,
                     input logic [31:0] d, input bit c);
    @(posedge sys_clk_i);
    if (!w) begin
      rd_q.push_back('{d, c});
    end
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge sys_clk_i);
    end while (wreq !== 1'h0);
    last = rdat;
    wr <= 1'h0;
    rd <= 1'h0;
  endtask

  // Poll the ready bits until they show the wanted cores
  task automatic wait_rdy(input logic [1:0] m);
    last = 32'h0000_0000;
    while (last[9:8] !== m) begin
      acc(0, REG_PWR, 32'h0000_0000, 0);
    end
  endtask

  // Read results
  always @(posedge sys_clk_i) begin
    adct_rd_s e;
    if (rst_n_i && rd && wreq === 1'h0 && rd_q.size() > 0) begin
      e = rd_q.pop_front();
      if (e.chk) begin
        chk_val(rdat, e.exp);
      end
    end
  end

  // Core results: sampling span, conversion span, early lead
  always @(posedge sys_clk_i) begin
    adct_cv_s e;
    cyc++;
    if (irq === 1'h1) begin
      irq_n++;
      t_irq = cyc;
    end
    for (int c = 0; c < 2; c++) begin
      if (trig[c] === 1'h1 && !busy[c]) begin
        busy[c] = 1'h1;
        t_trig[c] = cyc;
        slen[c] = -1;
        ccnt[c] = 0;
      end
      if (busy[c] && ps[c] && smp[c] === 1'h0 && slen[c] < 0) begin
        slen[c] = cyc - t_trig[c] - 1;
      end
      if (busy[c] && cnv[c] === 1'h1) begin
        ccnt[c]++;
      end
      if (drdy[c] === 1'h1) begin
        busy[c] = 1'h0;
        if (cv_q[c].size() == 0) begin
          chk_rng(1, 0, 0);
        end else begin
          e = cv_q[c].pop_front();
          chk_rng(slen[c], e.slo, e.shi);
          chk_rng(ccnt[c], 2 * e.conv, 2 * e.conv);
          chk_rng(cyc - t_irq, 2 * e.lead + 2, 2 * e.lead + 2);
        end
      end
    end
    ps = smp;
    if (cyc > 20000) begin
      bad_count++;
      summarize();
    end
  end

  initial begin
    logic [31:0] v;
    int base;
    int t0;
    int c;
    int r;
    int k;
    repeat (20) @(posedge sys_clk_i);
    rst_n_i <= 1'h1;
    for (int a = 0; a < 8; a++) begin
      acc(0, a[2:0], 32'h0000_0000, 1);
    end
    for (int i = 0; i < 4; i++) begin
      v = rnd();
      acc(1, ra[i], v, 0);
      acc(0, ra[i], v & rm[i], 1);
    end
    // Only core 0 may raise the ready interrupt
    acc(1, REG_RDYIRQ, 32'h0000_0001, 0);
    acc(1, REG_DLYEN, 32'h0000_0000, 0);
    base = irq_n;
    acc(1, REG_PWR, 32'h0000_0002, 0);
    wait_rdy(2'h2);
    repeat (4) @(posedge sys_clk_i);
    chk_rng(irq_n - base, 0, 0);
    base = irq_n;
    acc(1, REG_PWR, 32'h0000_0003, 0);
    wait_rdy(2'h3);
    repeat (4) @(posedge sys_clk_i);
    chk_rng(irq_n - base, 1, 1);
    // Longest warm-up code, only core 1 enabled
    acc(1, REG_PWR, 32'h0000_0000, 0);
    acc(1, REG_RDYIRQ, 32'h0000_0f02, 0);
    base = irq_n;
    t0 = cyc;
    acc(1, REG_PWR, 32'h0000_0003, 0);
    wait_rdy(2'h3);
    chk_rng(cyc - t0, (1 << 15) >> WS, ((1 << 15) >> WS) + 12);
    repeat (4) @(posedge sys_clk_i);
    chk_rng(irq_n - base, 1, 1);
    for (int i = 0; i < 8; i++) begin
      c = i % 2;
      r = i % 4;
      v = rnd();
      k = (i == 7) ? 1023 : int'(v[4:0]);
      acc(1, c ? REG_DLY1 : REG_DLY0, k, 0);
      acc(1, c ? REG_CFG1 : REG_CFG0, {19'h0_0000, i[2:0], r[1:0], 8'h00}, 0);
      acc(1, REG_DLYEN, {30'h0000_0000, i[1] & c[0], i[1] & !c[0]}, 0);
      if (i[1]) begin
        cv_q[c].push_back('{2 * (k + 2) - 1, 2 * (k + 2), 9 + 2 * r, i});
      end else begin
        cv_q[c].push_back('{0, 0, 9 + 2 * r, i});
      end
      fire <= 2'h1 << c;
      @(posedge sys_clk_i);
      fire <= 2'h0;
      repeat (6) @(posedge sys_clk_i);
      // A trigger while busy must be ignored
      fire <= 2'h1 << c;
      @(posedge sys_clk_i);
      fire <= 2'h0;
      while (cv_q[c].size() > 0) begin
        @(posedge sys_clk_i);
      end
      repeat (40) @(posedge sys_clk_i);
    end
    // Both cores raised early events; writing ones clears the sticky flags
    acc(0, REG_STAT, 32'h0000_0003, 1);
    acc(1, REG_STAT, 32'h0000_0003, 0);
    acc(0, REG_STAT, 32'h0000_0000, 1);
    summarize();
  end
endmodule // adct_core_timing_control_bench
